//--- rtl/meter_serial_port.sv
// Serial slave port and interrupt pin of the metering device
`timescale 1ns/10ps
`include "meter_port_defs.svh"

// Function
// - Interrupt pin pulled low while any enabled event is pending.
// - All shifting is timed by edges of the host serial clock.
// - Output data changes on each rising serial clock edge while transmitting.
// - Output stays released except while actively driving read data.
// - Input data captured on each falling serial clock edge.
// - Reset low holds port in reset, no transfer, no output driven.
module meter_serial_port (
   // Clock and synchronous reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Device reset pin
   input wire logic reset_n,
   // Serial pins
   input wire logic chip_select_n,
   input wire logic sclk,
   input wire logic serial_data_in,
   output logic serial_data_out,
   output logic serial_data_out_oe,
   // Core side
   input wire logic events_pending,
   input wire logic read_active,
   input wire meter_port_pkg::byte_t tx_byte,
   output logic tx_load,
   output meter_port_pkg::byte_t rx_byte,
   output logic rx_valid,
   // Interrupt pin, open drain
   output logic interrupt_request_n,
   output logic interrupt_request_oe
);
   import meter_port_pkg::*;

   typedef struct packed {
      logic [1:0] sclk_s;
      logic [1:0] cs_s;
      logic [1:0] din_s;
      logic [1:0] rst_s;
      logic sclk_d;
      logic [2:0] cnt;
      logic [2:0] tcnt;
      byte_t rx_sh;
      byte_t tx_sh;
      logic dout;
      logic oe;
      byte_t rx;
      logic rx_v;
      logic ld;
      logic irq;
   } state_s;

   // Registered state and its next value
   state_s st_r;
   state_s st_nxt;

   // Decoded conditions of the current cycle
   logic rise;
   logic fall;
   logic sel;
   logic in_rst;
   logic last_rx;
   logic last_tx;
   logic [7:0] rx_next;

   // Rising edge of a synchronised pin against its delayed copy
   function automatic logic edge_up(input logic now_v, input logic was_v);
      edge_up = now_v & ~was_v;
   endfunction

   // Falling edge of a synchronised pin against its delayed copy
   function automatic logic edge_down(input logic now_v, input logic was_v);
      edge_down = ~now_v & was_v;
   endfunction

   // Bit counter at the last bit of a byte, used by both directions
   function automatic logic at_last_bit(input logic [2:0] count);
      at_last_bit = (count == `BIT_LAST);
   endfunction

   // One bit shifted into the low end of a byte, MSB first on the wire
   function automatic byte_t shift_in(input byte_t cur, input logic bit_v);
      shift_in = {cur[6:0], bit_v};
   endfunction

   // Next bit counter value, wrapping after the last bit
   function automatic logic [2:0] count_up(input logic [2:0] count);
      count_up = count + `BIT_STEP;
   endfunction

   // Edges seen on the second sync stage only
   // The delayed copy resets to the idle level so reset makes no false edge
   assign rise = edge_up(st_r.sclk_s[1], st_r.sclk_d);
   assign fall = edge_down(st_r.sclk_s[1], st_r.sclk_d);

   // Select and reset pins, both active low, after their sync stages
   assign sel = ~st_r.cs_s[1];
   assign in_rst = ~st_r.rst_s[1];

   // Byte boundaries of the receive and transmit sides
   assign last_rx = at_last_bit(st_r.cnt);
   assign last_tx = at_last_bit(st_r.tcnt);

   // Receive shifter with the bit of this falling edge included
   assign rx_next = shift_in(st_r.rx_sh, st_r.din_s[1]);

   // Next state of the port
   always_comb begin
      st_nxt = st_r;

      // Two flip-flops on every pin before any logic reads it
      st_nxt.sclk_s = {st_r.sclk_s[0], sclk};
      st_nxt.cs_s = {st_r.cs_s[0], chip_select_n};
      st_nxt.din_s = {st_r.din_s[0], serial_data_in};
      st_nxt.rst_s = {st_r.rst_s[0], reset_n};
      st_nxt.sclk_d = st_r.sclk_s[1];

      // Pulses stand for a single cycle
      st_nxt.rx_v = 1'b0;
      st_nxt.ld = 1'b0;

      if (in_rst || !sel) begin
         // Partial transfer is dropped; a new select starts from bit 7
         st_nxt.cnt = `CNT_RST;
         st_nxt.tcnt = `CNT_RST;
         st_nxt.oe = 1'b0;
         st_nxt.rx_sh = `SHIFT_RST;
         // Follow the core while idle so the first bit is always fresh
         st_nxt.tx_sh = tx_byte;
         // The reset pin also silences the interrupt output
         st_nxt.irq = in_rst ? 1'b0 : events_pending;
      end else begin
         // No mask here: the core only reports enabled events
         st_nxt.irq = events_pending;

         if (fall) begin
            // Host presents data valid at the falling edge
            st_nxt.rx_sh = rx_next;
            st_nxt.cnt = count_up(st_r.cnt);
            if (last_rx) begin
               // Eighth bit in: hand the byte over for one cycle
               st_nxt.rx = rx_next;
               st_nxt.rx_v = 1'b1;
            end
         end

         if (rise) begin
            // Drive next bit so the host can sample on falling edge
            st_nxt.oe = read_active;
            st_nxt.dout = st_r.tx_sh[7];
            st_nxt.tcnt = count_up(st_r.tcnt);
            if (last_tx) begin
               // Bit 0 has just left; reloading earlier would cut it off
               st_nxt.tx_sh = tx_byte;
               st_nxt.ld = 1'b1;
            end else begin
               st_nxt.tx_sh = {st_r.tx_sh[6:0], 1'b0};
            end
         end

         // Enable drops on the next mclk edge, without waiting for a serial clock edge
         if (!read_active) begin
            st_nxt.oe = 1'b0;
         end
      end
   end

   // State register
   // Sync stages of the select and serial clock pins start high, so no edge follows reset
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_r <= '0;
         st_r.cs_s <= `SYNC_IDLE_HI;
         st_r.sclk_s <= `SYNC_IDLE_HI;
         st_r.sclk_d <= `SCLK_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Serial data pin; data keeps its last bit with the enable off, only the enable releases the line
   assign serial_data_out = st_r.dout;
   assign serial_data_out_oe = st_r.oe;

   // Open-drain interrupt: the pin is only ever pulled low
   assign interrupt_request_n = 1'b0;
   assign interrupt_request_oe = st_r.irq;

   // Core side of the port, all from flip-flops
   assign rx_byte = st_r.rx;
   assign rx_valid = st_r.rx_v;
   assign tx_load = st_r.ld;
endmodule

//--- rtl/meter_port_defs.svh
// Constants of the meter serial port
`ifndef METER_PORT_DEFS_SVH
`define METER_PORT_DEFS_SVH
`define SHIFT_BITS 8
`define SHIFT_RST 8'h00
`define CNT_RST 3'h0
`define SYNC_RST 2'h0
`define SYNC_IDLE_HI 2'h3
`define SCLK_IDLE 1'b1
`define BIT_LAST 3'h7
`define BIT_STEP 3'h1
`endif

//--- rtl/meter_port_pkg.sv
// Types of the meter serial port
package meter_port_pkg;
   typedef logic [7:0] byte_t;
endpackage

//--- verification/meter_port_checker.sv
// Pin assertions for the meter serial port
`timescale 1ns/10ps
module meter_port_checker (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Pins
   input wire logic reset_n,
   input wire logic chip_select_n,
   input wire logic sclk,
   input wire logic serial_data_out_oe,
   input wire logic interrupt_request_oe,
   // Core side
   input wire logic events_pending,
   input wire logic read_active,
   input wire logic rx_valid
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // No serial clock edge for nine samples means no byte can complete
   sequence clk_quiet; $stable(sclk) [*8] ##1 $stable(sclk); endsequence
   sequence idle_sel; chip_select_n [*8]; endsequence
   chk_irq_follow: assert property (reset_n && $changed(events_pending) |->
      ##[0:3] (interrupt_request_oe == events_pending)) else $error("irq lag");
   chk_clk_timed: assert property (clk_quiet |-> !rx_valid) else $error("rx no clk");
   chk_out_rise: assert property ($rose(serial_data_out_oe) |->
      $past(sclk, 2) && !chip_select_n) else $error("dout edge");
   chk_out_rel: assert property (!read_active [*2] |-> !serial_data_out_oe) else $error("oe");
   chk_sel_rx: assert property (idle_sel |=> !rx_valid) else $error("rx deselected");
   chk_irq_rst: assert property (!reset_n [*4] |-> !interrupt_request_oe)
      else $error("irq in reset");
   chk_pin_rst: assert property (!reset_n [*4] |-> !serial_data_out_oe && !rx_valid)
      else $error("reset pin");
   chk_desel_rel: assert property ($rose(chip_select_n) |-> ##[1:5] !serial_data_out_oe)
      else $error("deselect");
endmodule
bind meter_serial_port meter_port_checker chk (.mclk, .sys_rst, .reset_n, .chip_select_n,
   .sclk, .serial_data_out_oe, .events_pending, .read_active, .rx_valid, .interrupt_request_oe);

//--- verification/meter_host.sv
// Host model driving the serial pins
`timescale 1ns/10ps
module meter_host (
   output logic cs_n, sclk, din, rd7,
   input wire logic dout,
   output meter_port_pkg::byte_t rd
);
   // Clock parks high between frames, it never runs free
   initial begin
      cs_n = 1'b1;
      sclk = 1'b1;
      din = 1'b0;
      rd = 8'h00;
   end
   // Top bit of the read shifter
   assign rd7 = rd[7];
   // Bits go MSB first, din settles 32 ns before each fall
   task automatic xfer(input meter_port_pkg::byte_t b, input int n);
      cs_n = 1'b0;
      for (int i = 7; i > 7 - n; i--) begin
         din = b[i];
         #32 sclk = 1'b0;
         #32 sclk = 1'b1;
         #28 rd = {rd[6:0], dout};
         #4;
      end
      cs_n = 1'b1;
      din = ~din; // Released line, stale value must not be trusted
   endtask
endmodule

//--- verification/meter_serial_port_test.sv
// Self-checking bench for the meter serial port
`timescale 1ns/10ps
module meter_serial_port_test;
   import meter_port_pkg::*;
   logic mclk, sys_rst, rst_n, ev, ra, cs_n, sck, di, dout, rxv;
   byte_t txb, rxb, hrd, b;
   byte_t q[$];
   logic doe, irq, tld;
   int err_total = 0, n_tests = 0, n_load = 0;
   meter_serial_port uut (.mclk(mclk), .sys_rst(sys_rst), .reset_n(rst_n), .chip_select_n(cs_n),
      .sclk(sck), .serial_data_in(di), .serial_data_out(dout), .serial_data_out_oe(doe),
      .events_pending(ev), .read_active(ra), .tx_byte(txb), .tx_load(tld), .rx_byte(rxb),
      .rx_valid(rxv), .interrupt_request_n(), .interrupt_request_oe(irq));
   // A released data line shows the inverse so stale data cannot pass
   meter_host h (.cs_n(cs_n), .sclk(sck), .din(di), .rd7(), .dout(doe ? dout : ~dout),
      .rd(hrd));
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   // Each received byte is matched to the oldest note
   // Sampled mid-cycle, away from the edge that launches the pulses
   always @(negedge mclk) begin
      if (tld === 1'b1) n_load++;
      if (rxv === 1'b1) begin
         n_tests++;
         if (q.size() == 0 || rxb !== q[0]) begin
            err_total++;
            $display("unexpected rx_byte exp %h got %h", q.size() ? q[0] : 8'hxx, rxb);
         end
         if (q.size()) void'(q.pop_front());
      end
   end
   initial begin
      void'($urandom(32'hdc99));
      {sys_rst, rst_n, ev, ra, txb} = {3'b110, 1'b0, 8'h00};
      repeat (5) @(posedge mclk);
      #1 sys_rst = 1'b0;
      // Every fourth frame is cut after four bits, frame 9 runs under reset
      for (int k = 0; k < 12; k++) begin
         repeat (8) @(posedge mclk);
         #1 {txb, b, ev, ra, rst_n} = {8'($urandom), 8'($urandom), 1'($urandom), k[0], k != 9};
         if (k % 4 != 3 && k != 9) q.push_back(b);
         h.xfer(b, k % 4 == 3 ? 4 : 8);
         if (ra && k % 4 != 3 && k != 9 && (n_tests++ >= 0) && hrd !== txb) begin
            err_total++;
            $display("unexpected read data exp %h got %h", txb, hrd);
         end
         n_tests++;
         if (irq !== (ev & rst_n)) begin
            err_total++;
            $display("unexpected irq_oe exp %b got %b", ev & rst_n, irq);
         end
      end
      repeat (40) @(posedge mclk);
      // Eight full frames run outside reset, one load each
      n_tests++;
      if (n_load != 8) begin
         err_total++;
         $display("unexpected tx_load count exp 8 got %0d", n_load);
      end
      if (q.size()) begin
         err_total++;
         $display("unexpected pending bytes exp 0 got %0d", q.size());
      end
      print_verdict;
   end
   task automatic print_verdict;
      if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
endmodule
